// file: design/tsm_core.sv
// Notes on behaviour
// - Multiply-accumulate sums products of counted RAM pairs
// - Table shift moves table one word, inserts word
// - Instruction lengths span one to six bytes
// - Each flag: keep, clear, set, or from result
// - Shared flag: parity for logic, overflow otherwise
// - Restoring action reloads flags from saved word
// - Mask ones select pairs, zeros are skipped
// - System uses stack pointer; user uses pair five
// - Two pair classes, same pairs, distinct encodings
// - Status word has separate high and low bytes
//
// Our own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module tsm_core
	import tsm_pkg::*;
(
	input  wire logic          clk,
	input  wire logic          reset,
	input  wire logic [AW-1:0] s_axi_awaddr,
	input  wire logic          s_axi_awvalid,
	output logic               s_axi_awready,
	input  wire logic [31:0]   s_axi_wdata,
	input  wire logic [3:0]    s_axi_wstrb,
	input  wire logic          s_axi_wvalid,
	output logic               s_axi_wready,
	output logic [1:0]         s_axi_bresp,
	output logic               s_axi_bvalid,
	input  wire logic          s_axi_bready,
	input  wire logic [AW-1:0] s_axi_araddr,
	input  wire logic          s_axi_arvalid,
	output logic               s_axi_arready,
	output logic [31:0]        s_axi_rdata,
	output logic [1:0]         s_axi_rresp,
	output logic               s_axi_rvalid,
	input  wire logic          s_axi_rready
);
	// ==========================================================
	// Declarations
	logic [7:0]        psw_low_q, psw_low_d, psw_high_q, psw_high_d, psw_saved_q, psw_saved_d;
	logic [15:0]       sp_q, sp_d;
	logic [31:0]       opnd_q, opnd_d;
	logic [FA_W-1:0]   fact_q, fact_d;
	logic [10:0]       dec_q, dec_d;
	logic [7:0]        alu_res_q, alu_res_d, arg_q, arg_d;
	logic [31:0]       acc_q, acc_d;
	logic [15:0]       pair_q [8];
	logic [15:0]       pair_d [8];
	logic [15:0]       mem_q [RAM_WORDS];
	logic [15:0]       mem_d [RAM_WORDS];
	tsm_state_t        st_q, st_d;
	logic [2:0]        idx_q, idx_d;
	logic              pop_q, pop_d, user_q, user_d, done_q, done_d;
	logic [RIX_W-1:0]  ix_q, ix_d, iy_q, iy_d, cur_q, cur_d, base_q, base_d;
	logic              aw_got_q, aw_got_d, w_got_q, w_got_d;
	logic [AW-1:0]     awaddr_q, awaddr_d;
	logic [31:0]       wdata_q, wdata_d, rdata_q, rdata_d;
	logic [3:0]        wstrb_q, wstrb_d;
	logic              awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
	logic              arready_q, arready_d, rvalid_q, rvalid_d;
	logic [1:0]        bresp_q, bresp_d, rresp_q, rresp_d;
	logic              wr_fire, wr_err, busy;
	logic [7:0]        fu_res, fu_psw;
	tsm_alu_t          alu_sel;
	logic [3:0]        dec_len;
	logic              dec_ok, dec_pvalid, dec_alt;
	logic [2:0]        dec_pair;
	logic signed [31:0] prod;

	// Register window decode shared by read and write paths
	function automatic logic mapped(logic [AW-1:0] a);
		mapped = (a[AW-1:2] <= OFF_MAC_HI[AW-1:2])
		      || (a[AW-1:2] >= OFF_PAIR[AW-1:2] && a[AW-1:2] <= OFF_PAIR_END[AW-1:2])
		      || (a[AW-1:2] >= OFF_RAM[AW-1:2] && a[AW-1:2] <= OFF_RAM_END[AW-1:2]);
	endfunction : mapped

	// Byte-lane merge of a write into an old value
	function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] nw, logic [3:0] s);
		logic [31:0] m;
		m     = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
		merge = (old & ~m) | (nw & m);
	endfunction : merge

	// ==========================================================
	// Helpers: flag unit, length decoder, multiplier
	assign alu_sel = tsm_alu_t'(wdata_q[CMD_ALU_LSB +: 3]);
	assign busy    = (st_q != ST_IDLE);
	assign wr_fire = aw_got_q && w_got_q && !bvalid_q;
	// Busy refuses every write but the status clear, keeping state coherent
	assign wr_err  = !mapped(awaddr_q) || (busy && awaddr_q[AW-1:2] != OFF_STATUS[AW-1:2]);
	assign prod    = $signed(mem_q[ix_q]) * $signed(mem_q[iy_q]);

	tsm_flag_unit u_flags (
		.opnd_a    (opnd_q[7:0]),
		.opnd_b    (opnd_q[15:8]),
		.alu_op    (alu_sel),
		.flag_act  (fact_q),
		.psw_in    (psw_low_q),
		.psw_saved (psw_saved_q),
		.result    (fu_res),
		.psw_out   (fu_psw)
	);

	tsm_len_decode u_len (
		.opcode     (dec_q[7:0]),
		.mode       (dec_q[DEC_MODE_LSB +: 3]),
		.length     (dec_len),
		.len_ok     (dec_ok),
		.pair       (dec_pair),
		.pair_valid (dec_pvalid),
		.pair_alt   (dec_alt)
	);

	// ==========================================================
	// Core state: register writes, command launch, sequencers
	always_comb begin
		logic [31:0] wv;
		logic [15:0] ptr, nptr, val;
		logic        done_set, done_clr;
		wv          = 32'h0000_0000;
		ptr         = user_q ? pair_q[PAIR_FIVE] : sp_q;
		nptr        = ptr;
		val         = 16'h0000;
		done_set    = 1'b0;
		done_clr    = 1'b0;
		psw_low_d   = psw_low_q;
		psw_high_d  = psw_high_q;
		psw_saved_d = psw_saved_q;
		sp_d        = sp_q;
		opnd_d      = opnd_q;
		fact_d      = fact_q;
		dec_d       = dec_q;
		alu_res_d   = alu_res_q;
		arg_d       = arg_q;
		acc_d       = acc_q;
		pair_d      = pair_q;
		mem_d       = mem_q;
		st_d        = st_q;
		idx_d       = idx_q;
		pop_d       = pop_q;
		user_d      = user_q;
		ix_d        = ix_q;
		iy_d        = iy_q;
		cur_d       = cur_q;
		base_d      = base_q;
		if (wr_fire && !wr_err) begin
			if (awaddr_q[AW-1:2] == OFF_PSW_LOW[AW-1:2]) begin
				wv        = merge({24'h00_0000, psw_low_q}, wdata_q, wstrb_q);
				psw_low_d = wv[7:0];
			end else if (awaddr_q[AW-1:2] == OFF_PSW_HIGH[AW-1:2]) begin
				wv         = merge({24'h00_0000, psw_high_q}, wdata_q, wstrb_q);
				psw_high_d = wv[7:0];
			end else if (awaddr_q[AW-1:2] == OFF_PSW_SAVED[AW-1:2]) begin
				wv          = merge({24'h00_0000, psw_saved_q}, wdata_q, wstrb_q);
				psw_saved_d = wv[7:0];
			end else if (awaddr_q[AW-1:2] == OFF_SP[AW-1:2]) begin
				wv   = merge({16'h0000, sp_q}, wdata_q, wstrb_q);
				sp_d = wv[15:0];
			end else if (awaddr_q[AW-1:2] == OFF_OPERANDS[AW-1:2]) begin
				opnd_d = merge(opnd_q, wdata_q, wstrb_q);
			end else if (awaddr_q[AW-1:2] == OFF_FLAG_ACT[AW-1:2]) begin
				wv     = merge({17'h0_0000, fact_q}, wdata_q, wstrb_q);
				fact_d = wv[FA_W-1:0];
			end else if (awaddr_q[AW-1:2] == OFF_DECODE[AW-1:2]) begin
				wv    = merge({21'h00_0000, dec_q}, wdata_q, wstrb_q);
				dec_d = wv[10:0];
			end else if (awaddr_q[AW-1:2] == OFF_STATUS[AW-1:2]) begin
				done_clr = wdata_q[STS_DONE] && wstrb_q[0];         // Write one to clear
			end else if (awaddr_q[AW-1:2] >= OFF_PAIR[AW-1:2]
			          && awaddr_q[AW-1:2] <= OFF_PAIR_END[AW-1:2]) begin
				wv                   = merge({16'h0000, pair_q[awaddr_q[4:2]]}, wdata_q, wstrb_q);
				pair_d[awaddr_q[4:2]] = wv[15:0];
			end else if (awaddr_q[AW-1:2] >= OFF_RAM[AW-1:2]) begin
				wv                   = merge({16'h0000, mem_q[awaddr_q[6:2]]}, wdata_q, wstrb_q);
				mem_d[awaddr_q[6:2]] = wv[15:0];
			end else if (awaddr_q[AW-1:2] == OFF_CMD[AW-1:2]) begin
				// Commands take effect from any write, whatever its byte strobes
				arg_d = wdata_q[CMD_ARG_LSB +: 8];
				unique case (tsm_cmd_t'(wdata_q[CMD_OP_LSB +: 3]))
					CMD_NONE: ;
					CMD_ALU: begin
						psw_low_d = fu_psw;
						alu_res_d = fu_res;
						done_set  = 1'b1;
					end
					CMD_PUSH_SYS, CMD_POP_SYS, CMD_PUSH_USR, CMD_POP_USR: begin
						st_d   = ST_STACK;
						pop_d  = wdata_q[CMD_OP_LSB] == 1'b1;          // Pops have odd codes
						user_d = wdata_q[CMD_OP_LSB +: 3] >= CMD_PUSH_USR;
						idx_d  = wdata_q[CMD_OP_LSB] ? PAIR_FIRST : PAIR_LAST;
					end
					CMD_MAC: begin
						st_d  = ST_MAC;
						acc_d = 32'h0000_0000;
						ix_d  = wdata_q[CMD_BX_LSB +: RIX_W];
						iy_d  = wdata_q[CMD_BY_LSB +: RIX_W];
					end
					CMD_SHIFT: begin
						st_d   = ST_SHIFT;
						base_d = wdata_q[CMD_BX_LSB +: RIX_W];
						cur_d  = wdata_q[CMD_BX_LSB +: RIX_W] + wdata_q[CMD_ARG_LSB +: RIX_W];
					end
				endcase
			end
		end
		unique case (st_q)
			ST_IDLE: ;
			// One mask position per cycle; push walks down, pop walks up
			ST_STACK: begin
				if (arg_q[idx_q]) begin
					if (pop_q) begin
						val  = mem_q[ptr[RIX_W:1]];
						nptr = ptr + PTR_STEP;
						if (user_q && idx_q == PAIR_FIVE)
							{psw_high_d, psw_low_d} = val;
						else
							pair_d[idx_q] = val;
					end else begin
						nptr = ptr - PTR_STEP;
						if (user_q && idx_q == PAIR_FIVE)
							mem_d[nptr[RIX_W:1]] = {psw_high_q, psw_low_q};
						else
							mem_d[nptr[RIX_W:1]] = pair_q[idx_q];
					end
					if (user_q)
						pair_d[PAIR_FIVE] = nptr;
					else
						sp_d = nptr;
				end
				if (idx_q == (pop_q ? PAIR_LAST : PAIR_FIRST)) begin
					st_d     = ST_IDLE;
					done_set = 1'b1;
				end else begin
					idx_d = pop_q ? idx_q + 3'h1 : idx_q - 3'h1;
				end
			end
			// One product per cycle; count set by the 8-bit argument, RAM indices wrap
			ST_MAC: begin
				if (arg_q == 8'h00) begin
					st_d     = ST_IDLE;
					done_set = 1'b1;
				end else begin
					acc_d = acc_q + prod;
					ix_d  = ix_q + 5'h01;
					iy_d  = iy_q + 5'h01;
					arg_d = arg_q - 8'h01;
				end
			end
			// Move top word first so no entry is overwritten before it moves
			ST_SHIFT: begin
				if (cur_q == base_q) begin
					mem_d[base_q] = opnd_q[31:16];
					st_d          = ST_IDLE;
					done_set      = 1'b1;
				end else begin
					mem_d[cur_q] = mem_q[cur_q - 5'h01];
					cur_d        = cur_q - 5'h01;
				end
			end
		endcase
		done_d = (done_q && !done_clr) || done_set;                   // Set beats clear
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			psw_low_q   <= PSW_LOW_RST;
			psw_high_q  <= PSW_HIGH_RST;
			psw_saved_q <= PSW_LOW_RST;
			sp_q        <= SP_RST;
			opnd_q      <= 32'h0000_0000;
			fact_q      <= '0;
			dec_q       <= '0;
			alu_res_q   <= 8'h00;
			arg_q       <= 8'h00;
			acc_q       <= 32'h0000_0000;
			st_q        <= ST_IDLE;
			idx_q       <= PAIR_FIRST;
			pop_q       <= 1'b0;
			user_q      <= 1'b0;
			done_q      <= 1'b0;
			ix_q        <= '0;
			iy_q        <= '0;
			cur_q       <= '0;
			base_q      <= '0;
			for (int i = 0; i < 8; i++) pair_q[i] <= 16'h0000;
			for (int i = 0; i < RAM_WORDS; i++) mem_q[i] <= 16'h0000;
		end else begin
			psw_low_q   <= psw_low_d;
			psw_high_q  <= psw_high_d;
			psw_saved_q <= psw_saved_d;
			sp_q        <= sp_d;
			opnd_q      <= opnd_d;
			fact_q      <= fact_d;
			dec_q       <= dec_d;
			alu_res_q   <= alu_res_d;
			arg_q       <= arg_d;
			acc_q       <= acc_d;
			st_q        <= st_d;
			idx_q       <= idx_d;
			pop_q       <= pop_d;
			user_q      <= user_d;
			done_q      <= done_d;
			ix_q        <= ix_d;
			iy_q        <= iy_d;
			cur_q       <= cur_d;
			base_q      <= base_d;
			pair_q      <= pair_d;
			mem_q       <= mem_d;
		end
	end

	// ==========================================================
	// AXI4-Lite slave: address and data taken in either order
	always_comb begin
		aw_got_d = aw_got_q;
		awaddr_d = awaddr_q;
		w_got_d  = w_got_q;
		wdata_d  = wdata_q;
		wstrb_d  = wstrb_q;
		bvalid_d = bvalid_q;
		bresp_d  = bresp_q;
		rvalid_d = rvalid_q;
		rdata_d  = rdata_q;
		rresp_d  = rresp_q;
		if (awready_q && s_axi_awvalid) begin
			aw_got_d = 1'b1;
			awaddr_d = s_axi_awaddr;
		end
		if (wready_q && s_axi_wvalid) begin
			w_got_d = 1'b1;
			wdata_d = s_axi_wdata;
			wstrb_d = s_axi_wstrb;
		end
		if (bvalid_q && s_axi_bready)
			bvalid_d = 1'b0;
		if (wr_fire) begin
			aw_got_d = 1'b0;
			w_got_d  = 1'b0;
			bvalid_d = 1'b1;
			bresp_d  = wr_err ? RESP_SLVERR : RESP_OKAY;
		end
		if (rvalid_q && s_axi_rready)
			rvalid_d = 1'b0;
		if (arready_q && s_axi_arvalid) begin
			rvalid_d = 1'b1;
			rresp_d  = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			rdata_d  = 32'h0000_0000;
			if (!mapped(s_axi_araddr))
				rdata_d = 32'h0000_0000;                          // No alias data on refusal
			else if (s_axi_araddr[AW-1:2] >= OFF_RAM[AW-1:2])
				rdata_d = {16'h0000, mem_q[s_axi_araddr[6:2]]};
			else if (s_axi_araddr[AW-1:2] >= OFF_PAIR[AW-1:2])
				rdata_d = {16'h0000, pair_q[s_axi_araddr[4:2]]};
			else unique case (s_axi_araddr[5:2])
				OFF_PSW_LOW[5:2]:   rdata_d = {24'h00_0000, psw_low_q};
				OFF_PSW_HIGH[5:2]:  rdata_d = {24'h00_0000, psw_high_q};
				OFF_PSW_SAVED[5:2]: rdata_d = {24'h00_0000, psw_saved_q};
				OFF_SP[5:2]:        rdata_d = {16'h0000, sp_q};
				OFF_OPERANDS[5:2]:  rdata_d = opnd_q;
				OFF_FLAG_ACT[5:2]:  rdata_d = {17'h0_0000, fact_q};
				OFF_STATUS[5:2]:    rdata_d = {16'h0000, alu_res_q, 6'h00, done_q, busy};
				OFF_DECODE[5:2]:    rdata_d = {10'h000, dec_alt, dec_pvalid, dec_pair,
				                               !dec_ok, dec_len, 1'b0, dec_q};
				OFF_MAC_LO[5:2]:    rdata_d = {16'h0000, acc_q[15:0]};
				OFF_MAC_HI[5:2]:    rdata_d = {16'h0000, acc_q[31:16]};
				default:            rdata_d = 32'h0000_0000;
			endcase
		end
		awready_d = !aw_got_d && !bvalid_d;
		wready_d  = !w_got_d && !bvalid_d;
		arready_d = !rvalid_d;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			aw_got_q  <= 1'b0;
			awaddr_q  <= '0;
			w_got_q   <= 1'b0;
			wdata_q   <= 32'h0000_0000;
			wstrb_q   <= 4'h0;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h0000_0000;
			rresp_q   <= RESP_OKAY;
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			arready_q <= 1'b0;
		end else begin
			aw_got_q  <= aw_got_d;
			awaddr_q  <= awaddr_d;
			w_got_q   <= w_got_d;
			wdata_q   <= wdata_d;
			wstrb_q   <= wstrb_d;
			bvalid_q  <= bvalid_d;
			bresp_q   <= bresp_d;
			rvalid_q  <= rvalid_d;
			rdata_q   <= rdata_d;
			rresp_q   <= rresp_d;
			awready_q <= awready_d;
			wready_q  <= wready_d;
			arready_q <= arready_d;
		end
	end

	assign s_axi_awready = awready_q;
	assign s_axi_wready  = wready_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;
endmodule : tsm_core
`default_nettype wire

// file: design/tsm_pkg.sv
`default_nettype none
package tsm_pkg;
	// ==========================================================
	// Register map, one aligned 32-bit word each
	localparam int unsigned   AW            = 12;
	localparam logic [AW-1:0] OFF_PSW_LOW   = 12'h000;
	localparam logic [AW-1:0] OFF_PSW_HIGH  = 12'h004;
	localparam logic [AW-1:0] OFF_PSW_SAVED = 12'h008;
	localparam logic [AW-1:0] OFF_SP        = 12'h00C;
	localparam logic [AW-1:0] OFF_OPERANDS  = 12'h010;
	localparam logic [AW-1:0] OFF_FLAG_ACT  = 12'h014;
	localparam logic [AW-1:0] OFF_CMD       = 12'h018;
	localparam logic [AW-1:0] OFF_STATUS    = 12'h01C;
	localparam logic [AW-1:0] OFF_DECODE    = 12'h020;
	localparam logic [AW-1:0] OFF_MAC_LO    = 12'h024;
	localparam logic [AW-1:0] OFF_MAC_HI    = 12'h028;
	localparam logic [AW-1:0] OFF_PAIR      = 12'h040;
	localparam logic [AW-1:0] OFF_PAIR_END  = 12'h05C;
	localparam logic [AW-1:0] OFF_RAM       = 12'h100;
	localparam logic [AW-1:0] OFF_RAM_END   = 12'h17C;
	localparam logic [1:0]    RESP_OKAY     = 2'h0;
	localparam logic [1:0]    RESP_SLVERR   = 2'h2;
	// ==========================================================
	// Storage sizes and reset values
	localparam int unsigned   RAM_WORDS     = 32;
	localparam int unsigned   RIX_W         = 5;
	localparam logic [2:0]    PAIR_FIVE     = 3'h5;
	localparam logic [2:0]    PAIR_FIRST    = 3'h0;
	localparam logic [2:0]    PAIR_LAST     = 3'h7;
	localparam logic [15:0]   PTR_STEP      = 16'h0002;
	localparam logic [15:0]   SP_RST        = 16'h0040;
	localparam logic [7:0]    PSW_LOW_RST   = 8'h00;
	localparam logic [7:0]    PSW_HIGH_RST  = 8'h00;
	// ==========================================================
	// Flag positions in the status word low byte
	localparam int unsigned   FLAG_CY       = 0;
	localparam int unsigned   FLAG_PV       = 2;
	localparam int unsigned   FLAG_AC       = 4;
	localparam int unsigned   FLAG_Z        = 6;
	localparam int unsigned   FLAG_S        = 7;
	// Flag action field: three bits per flag
	localparam int unsigned   FA_S_LSB      = 0;
	localparam int unsigned   FA_Z_LSB      = 3;
	localparam int unsigned   FA_AC_LSB     = 6;
	localparam int unsigned   FA_PV_LSB     = 9;
	localparam int unsigned   FA_CY_LSB     = 12;
	localparam int unsigned   FA_W          = 15;
	// Command word fields
	localparam int unsigned   CMD_OP_LSB    = 0;
	localparam int unsigned   CMD_ALU_LSB   = 4;
	localparam int unsigned   CMD_ARG_LSB   = 8;
	localparam int unsigned   CMD_BX_LSB    = 16;
	localparam int unsigned   CMD_BY_LSB    = 21;
	// Status bits and decode fields
	localparam int unsigned   STS_BUSY      = 0;
	localparam int unsigned   STS_DONE      = 1;
	localparam int unsigned   DEC_MODE_LSB  = 8;
	localparam logic [3:0]    LEN_MIN       = 4'h1;
	localparam logic [3:0]    LEN_MAX       = 4'h6;
	localparam logic [3:0]    PAIR_CLS_RP   = 4'h6;
	localparam logic [3:0]    PAIR_CLS_ALT  = 4'h7;
	// ==========================================================
	// Enumerations
	typedef enum logic [2:0] {
		FA_KEEP, FA_ZERO, FA_ONE, FA_RESULT, FA_PARITY, FA_OVERFLOW, FA_RESTORE
	} tsm_fact_t;
	typedef enum logic [2:0] {
		ALU_ADD, ALU_ADDC, ALU_SUB, ALU_SUBC, ALU_AND, ALU_OR, ALU_XOR
	} tsm_alu_t;
	typedef enum logic [2:0] {
		CMD_NONE, CMD_ALU, CMD_PUSH_SYS, CMD_POP_SYS, CMD_PUSH_USR, CMD_POP_USR,
		CMD_MAC, CMD_SHIFT
	} tsm_cmd_t;
	typedef enum logic [1:0] {ST_IDLE, ST_STACK, ST_MAC, ST_SHIFT} tsm_state_t;
endpackage : tsm_pkg
`default_nettype wire

// file: design/tsm_flag_unit.sv
`timescale 1ns/1ps
`default_nettype none
module tsm_flag_unit
	import tsm_pkg::*;
(
	input  wire logic [7:0]      opnd_a,
	input  wire logic [7:0]      opnd_b,
	input  wire tsm_alu_t        alu_op,
	input  wire logic [FA_W-1:0] flag_act,
	input  wire logic [7:0]      psw_in,
	input  wire logic [7:0]      psw_saved,
	output logic      [7:0]      result,
	output logic      [7:0]      psw_out
);
	logic [8:0] wide;
	logic [4:0] nib;
	logic       cin, ovf, par, arith;

	// One action per flag: keep, force, result, parity, overflow or restore
	function automatic logic pick(logic [2:0] act, logic old, logic val, logic sav,
	                              logic p, logic v);
		unique case (tsm_fact_t'(act))
			FA_KEEP:     pick = old;
			FA_ZERO:     pick = 1'b0;
			FA_ONE:      pick = 1'b1;
			FA_RESULT:   pick = val;
			FA_PARITY:   pick = p;
			FA_OVERFLOW: pick = v;
			FA_RESTORE:  pick = sav;
			default:     pick = old;
		endcase
	endfunction : pick

	// ==========================================================
	// Eight-bit arithmetic and logic with carry, half carry, overflow
	always_comb begin
		cin   = psw_in[FLAG_CY] && (alu_op == ALU_ADDC || alu_op == ALU_SUBC);
		wide  = 9'h000;
		nib   = 5'h00;
		arith = 1'b1;
		unique case (alu_op)
			ALU_ADD, ALU_ADDC: begin
				wide = {1'b0, opnd_a} + {1'b0, opnd_b} + {8'h00, cin};
				nib  = {1'b0, opnd_a[3:0]} + {1'b0, opnd_b[3:0]} + {4'h0, cin};
			end
			ALU_SUB, ALU_SUBC: begin
				wide = {1'b0, opnd_a} - {1'b0, opnd_b} - {8'h00, cin};
				nib  = {1'b0, opnd_a[3:0]} - {1'b0, opnd_b[3:0]} - {4'h0, cin};
			end
			ALU_AND: begin
				wide  = {1'b0, opnd_a & opnd_b};
				arith = 1'b0;
			end
			ALU_OR: begin
				wide  = {1'b0, opnd_a | opnd_b};
				arith = 1'b0;
			end
			ALU_XOR: begin
				wide  = {1'b0, opnd_a ^ opnd_b};
				arith = 1'b0;
			end
			default: arith = 1'b0;
		endcase
		result = wide[7:0];
		par    = ~^wide[7:0];                     // Set for an even count of ones
		if (alu_op == ALU_SUB || alu_op == ALU_SUBC)
			ovf = (opnd_a[7] != opnd_b[7]) && (wide[7] != opnd_a[7]);
		else
			ovf = (opnd_a[7] == opnd_b[7]) && (wide[7] != opnd_a[7]) && arith;
		psw_out = psw_in;
		// Each flag takes exactly one of the coded actions
		psw_out[FLAG_S]  = pick(flag_act[FA_S_LSB +: 3], psw_in[FLAG_S], wide[7],
		                        psw_saved[FLAG_S], par, ovf);
		psw_out[FLAG_Z]  = pick(flag_act[FA_Z_LSB +: 3], psw_in[FLAG_Z], wide[7:0] == 8'h00,
		                        psw_saved[FLAG_Z], par, ovf);
		psw_out[FLAG_AC] = pick(flag_act[FA_AC_LSB +: 3], psw_in[FLAG_AC], nib[4],
		                        psw_saved[FLAG_AC], par, ovf);
		// Shared flag: parity for logic, overflow for arithmetic
		psw_out[FLAG_PV] = pick(flag_act[FA_PV_LSB +: 3], psw_in[FLAG_PV], arith ? ovf : par,
		                        psw_saved[FLAG_PV], par, ovf);
		psw_out[FLAG_CY] = pick(flag_act[FA_CY_LSB +: 3], psw_in[FLAG_CY], wide[8],
		                        psw_saved[FLAG_CY], par, ovf);
	end
endmodule : tsm_flag_unit
`default_nettype wire

// file: design/tsm_len_decode.sv
`timescale 1ns/1ps
`default_nettype none
module tsm_len_decode
	import tsm_pkg::*;
(
	input  wire logic [7:0] opcode,
	input  wire logic [2:0] mode,
	output logic      [3:0] length,
	output logic            len_ok,
	output logic      [2:0] pair,
	output logic            pair_valid,
	output logic            pair_alt
);
	logic [3:0] base;

	// ==========================================================
	// Base length per opcode group, addressing mode adds bytes
	always_comb begin
		unique case (opcode[7:5])
			3'h0, 3'h1: base = 4'h1;
			3'h2, 3'h3: base = 4'h2;
			3'h4, 3'h5: base = 4'h3;
			3'h6:       base = 4'h4;
			3'h7:       base = 4'h2;
		endcase
		length = base + {1'b0, mode};
		len_ok = (length >= LEN_MIN) && (length <= LEN_MAX);
		// Two encodings name the same eight pairs
		pair       = opcode[2:0];
		pair_valid = (opcode[7:4] == PAIR_CLS_RP) || (opcode[7:4] == PAIR_CLS_ALT);
		pair_alt   = (opcode[7:4] == PAIR_CLS_ALT);
	end
endmodule : tsm_len_decode
`default_nettype wire

// file: tb/tsm_core_checker.sv
`timescale 1ns/1ps
`default_nettype none
module tsm_core_checker (
	input wire logic        clk,
	input wire logic        reset,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready
);
	// ==========================================================
	// Register access handshakes, one clock domain
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
	a_read_lat: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid && !s_axi_arready) else $error("read answer late");
	a_read_back: assert property (s_axi_rvalid && s_axi_rready |=>
		!s_axi_rvalid && s_axi_arready) else $error("read channel not reopened");
	a_write_back: assert property (s_axi_bvalid && s_axi_bready |=>
		!s_axi_bvalid && s_axi_awready && s_axi_wready) else $error("write not reopened");
	a_write_quiet: assert property (s_axi_bvalid |->
		!s_axi_awready && !s_axi_wready) else $error("write taken during answer");
	a_bresp_code: assert property (s_axi_bvalid |->
		s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2) else $error("bad write code");
	a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |->
		s_axi_rdata == 32'h0) else $error("refused read carries data");
endmodule : tsm_core_checker
bind tsm_core tsm_core_checker i_chk (.*);
`default_nettype wire

// file: tb/tb_tsm_core.sv
`timescale 1ns/1ps
`default_nettype none
module tb_tsm_core;
	import tsm_pkg::*;
	logic clk = 0, reset = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
	logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, ra, rw;
	logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, d, m;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [1:0] s_axi_bresp, s_axi_rresp, p;
	logic [7:0] r, s, a, b, e;
	logic [15:0] pv [8];
	logic [14:0] fa [6] = '{15'h0000, 15'h1249, 15'h2492, 15'h6DB6, 15'h0600, 15'h36DB};
	logic [3:0] base [8] = '{4'h1, 4'h1, 4'h2, 4'h2, 4'h3, 4'h3, 4'h4, 4'h2};
	int failures = 0, tests_run = 0, n, i, k;
	tsm_core i_dut (.*);
	always #2.5 clk = ~clk;
	// ==========================================================
	// Checking and bus tasks
	task automatic chk(input logic [31:0] v, input logic [31:0] x);
		tests_run++;
		if (v !== x) begin
			failures++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, v, x);
		end
	endtask : chk
	task automatic stop_test;
		$display("failures=%0d tests_run=%0d", failures, tests_run);
		if (failures == 0 && tests_run > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : stop_test
	// Sample at the falling edge so the answer never races the driver
	task automatic tick;
		if (++n > 99) begin
			failures++;
			stop_test();
		end
		@(negedge clk);
	endtask : tick
	task automatic wr(input logic [11:0] ad, input logic [31:0] v);
		@(posedge clk);
		{s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {ad, v, 3'h7};
		{ra, rw, n} = {2'h3, 32'h0};
		while (ra || rw) begin
			tick();
			ra = ra && !s_axi_awready;
			rw = rw && !s_axi_wready;
			@(posedge clk);
			{s_axi_awvalid, s_axi_wvalid} <= {ra, rw};
		end
		do tick(); while (!s_axi_bvalid);
		p = s_axi_bresp;
		@(posedge clk);
		s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [11:0] ad);
		@(posedge clk);
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {ad, 2'h3};
		n = 0;
		do tick(); while (!s_axi_arready);
		@(posedge clk);
		s_axi_arvalid <= 1'b0;
		do tick(); while (!s_axi_rvalid);
		{d, p} = {s_axi_rdata, s_axi_rresp};
		@(posedge clk);
		s_axi_rready <= 1'b0;
	endtask : rd
	task automatic idle;
		d = 32'h1;
		for (i = 0; d[STS_BUSY] && i < 30; i++) rd(OFF_STATUS);
		chk(d[1:0], 32'h2);
		wr(OFF_STATUS, 32'h2);
	endtask : idle
	function automatic logic [7:0] fexp(int c);
		logic [8:0] t;
		t = a + b;
		case (c)
			0: return r;
			1: return r & 8'h2A;
			2: return r | 8'hD5;
			3: return (r & 8'h2A) | (s & 8'hD5);
			5: return {t[7], t[7:0] == 8'h0, r[5], {1'b0, a[3:0]} + b[3:0] > 5'hF, r[3],
			           a[7] == b[7] && t[7] != a[7], r[1], t[8]};
			default: return {r[7:3], ~^(a ^ b), r[1:0]};
		endcase
	endfunction : fexp
	// ==========================================================
	// Main sequence
	initial begin
		void'($urandom(32'h304B));
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		rd(OFF_SP);
		chk(d, {16'h0, SP_RST});
		rd(12'h0FC);
		chk(p, RESP_SLVERR);
		{r, s, a, b} = $urandom;
		wr(OFF_PSW_LOW, r);
		wr(OFF_PSW_HIGH, s);
		rd(OFF_PSW_LOW);
		chk(d, r);
		rd(OFF_PSW_HIGH);
		chk(d, s);
		for (k = 0; k < 6; k++) begin
			{r, s, a, b} = $urandom;
			wr(OFF_PSW_LOW, r);
			wr(OFF_PSW_SAVED, s);
			wr(OFF_OPERANDS, {b, a});
			wr(OFF_FLAG_ACT, fa[k]);
			wr(OFF_CMD, (k == 4) ? 32'h61 : 32'h01);
			rd(OFF_PSW_LOW);
			chk(d, fexp(k));
		end
		for (k = 0; k < 8; k++) begin
			a = (k == 7) ? 8'hC0 : 8'($urandom);
			if (k < 3) a[7:4] = 4'h5 + 4'(k);
			e = (k == 7) ? 8'h3 : 8'($urandom_range(7));
			wr(OFF_DECODE, {e[2:0], a});
			rd(OFF_DECODE);
			e = base[a[7:5]] + e;
			chk(d[21:12], {a[7:4] == 4'h7, a[7:5] == 3'h3, a[2:0], e > 8'h6, e[3:0]});
		end
		idle();
		e = $urandom;
		for (k = 0; k < 8; k++) begin
			pv[k] = 16'($urandom);
			wr(OFF_PAIR + 12'(4 * k), pv[k]);
		end
		wr(OFF_CMD, {16'h0, e, 8'h02});
		idle();
		rd(OFF_SP);
		chk(d, 32'h40 - 2 * $countones(e));
		for (k = 0; k < 8; k++) wr(OFF_PAIR + 12'(4 * k), 32'h0);
		wr(OFF_CMD, {16'h0, e, 8'h03});
		idle();
		for (k = 0; k < 8; k++) begin
			rd(OFF_PAIR + 12'(4 * k));
			chk(d, e[k] ? pv[k] : 16'h0);
		end
		for (k = 0; k < 4; k++) wr(OFF_RAM + 12'(4 * k), pv[k]);
		wr(OFF_CMD, 32'h0040_0206);
		idle();
		m = $signed(pv[0]) * $signed(pv[2]) + $signed(pv[1]) * $signed(pv[3]);
		rd(OFF_MAC_LO);
		chk(d, m[15:0]);
		rd(OFF_MAC_HI);
		chk(d, m[31:16]);
		wr(OFF_OPERANDS, {pv[7], 16'h0});
		wr(OFF_CMD, 32'h0307);
		idle();
		for (k = 0; k < 4; k++) begin
			rd(OFF_RAM + 12'(4 * k));
			chk(d, (k == 0) ? pv[7] : pv[k - 1]);
		end
		{r, s} = 16'($urandom);
		wr(OFF_PSW_LOW, r);
		wr(OFF_PSW_HIGH, s);
		wr(OFF_PAIR + 12'h014, 32'h20);
		wr(OFF_CMD, 32'h2004);
		idle();
		rd(OFF_RAM + 12'h03C);
		chk(d, {s, r});
		stop_test();
	end
endmodule : tb_tsm_core
`default_nettype wire
